// ===== drm_pkg.sv
package drm_pkg;
    // panel geometry
    localparam int unsigned NUM_COLS       = 240;
    localparam int unsigned NUM_ROWS       = 160;
    localparam int unsigned BYTES_PER_ROW  = 30;
    localparam int unsigned FULL_BYTES     = 4800;
    localparam int unsigned PIX_PER_BYTE   = 8;
    localparam int unsigned FRAME_STRETCH  = 5;
    localparam logic [7:0]  LAST_COL       = 8'hEF;
    localparam logic [7:0]  LAST_ROW       = 8'h9F;
    localparam logic [7:0]  LAST_BYTE_COL  = 8'h1D;
    localparam logic [12:0] LAST_FULL_BYTE = 13'h12BF;
    // serial commands
    localparam logic [7:0]  CMD_FULL_UPDATE = 8'h18;
    localparam logic [7:0]  CMD_PART_UPDATE = 8'h19;
    localparam logic [7:0]  CMD_SLEEP       = 8'h20;
    localparam logic [7:0]  CMD_SOFT_RESET  = 8'h24;
    localparam logic [7:0]  CMD_PP_CLEAR    = 8'h2A;
    // timing
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned RST_PULSE_NS    = 2000;
    localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_NS * 50 + 999) / 1000;
    localparam int unsigned RESET_SEQ_MS    = 1000;
    localparam int unsigned RESET_SEQ_CYC   = RESET_SEQ_MS * (CLK_HZ / 1000);
    localparam int unsigned FIFO_DEPTH      = 8;
    localparam int unsigned BYTE_W          = 8;
    typedef enum logic [2:0] {
        DRM_RESETTING, DRM_SLEEP, DRM_IDLE, DRM_RECV, DRM_UPDATE, DRM_ERASE
    } drm_state_t;
endpackage : drm_pkg

// ===== drm_fifo.sv
`timescale 1ns/1ps
module drm_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             arst_n_in,
    // write side
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    // read side
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    // flush
    input  wire logic             flush_in
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              do_wr = wr_valid_in && (count != DEPTH[AW:0]);
    wire              do_rd = rd_valid_out && rd_ready_in;

    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != '0);
    assign rd_data_out  = mem[rd_ptr];

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) wr_ptr <= AW'(wr_ptr + 1'b1);
            if (do_rd) rd_ptr <= AW'(rd_ptr + 1'b1);
            count <= (AW+1)'(count + do_wr - do_rd);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (do_wr) mem[wr_ptr] <= wr_data_in;
    end
endmodule : drm_fifo

// ===== drm_top.sv
`timescale 1ns/1ps
module drm_top
    import drm_pkg::*;
#(
    parameter int unsigned RESET_SEQ_CYCLES = RESET_SEQ_CYC
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    // host pins
    input  wire logic       reset_pin_n_in,
    input  wire logic       cs_n_in,
    input  wire logic       sck_in,
    input  wire logic       si_in,
    output logic            busy_out,
    // panel pixel stream
    output logic [7:0]      pix_col_out,
    output logic [7:0]      pix_row_out,
    output logic            pix_bright_out,
    output logic [2:0]      pix_width_out,
    output logic [2:0]      pix_height_out,
    output logic            pix_valid_out,
    output logic            interpixel_dark_out,
    output logic            sleeping_out
);
    // =========================================================
    // pin synchronisers
    // =========================================================
    logic [1:0] rst_sync;
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] si_sync;
    logic       sck_prev;
    logic       cs_prev;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync <= 2'h3;
            cs_sync  <= 2'h3;
            sck_sync <= 2'h0;
            si_sync  <= 2'h0;
            sck_prev <= 1'b0;
            cs_prev  <= 1'b1;
        end else begin
            rst_sync <= {rst_sync[0], reset_pin_n_in};
            cs_sync  <= {cs_sync[0], cs_n_in};
            sck_sync <= {sck_sync[0], sck_in};
            si_sync  <= {si_sync[0], si_in};
            sck_prev <= sck_sync[1];
            cs_prev  <= cs_sync[1];
        end
    end

    wire rst_lvl  = rst_sync[1];
    wire cs_lvl   = cs_sync[1];
    wire sck_fall = sck_prev && !sck_sync[1];
    wire cs_rise  = !cs_prev && cs_lvl;

    // =========================================================
    // reset pulse qualification
    // =========================================================
    logic [7:0] rst_low_cnt;
    logic       rst_prev;
    wire        rst_pulse_ok = (rst_low_cnt >= 8'(RST_PULSE_CYC));
    wire        hw_reset_trig = rst_lvl && !rst_prev && rst_pulse_ok;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_low_cnt <= 8'h00;
            rst_prev    <= 1'b1;
        end else begin
            rst_prev <= rst_lvl;
            if (rst_lvl)
                rst_low_cnt <= 8'h00;
            else if (!rst_pulse_ok)
                rst_low_cnt <= 8'(rst_low_cnt + 1'b1);
        end
    end

    // =========================================================
    // serial byte receiver, msb first, latched on sck fall
    // =========================================================
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic       byte_stb;
    logic [7:0] byte_val;
    wire  [7:0] next_shift = {shift[6:0], si_sync[1]};

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift    <= 8'h00;
            bit_cnt  <= 3'h0;
            byte_stb <= 1'b0;
            byte_val <= 8'h00;
        end else begin
            byte_stb <= 1'b0;
            if (cs_lvl) begin
                bit_cnt <= 3'h0;
            end else if (sck_fall) begin
                shift   <= next_shift;
                bit_cnt <= 3'(bit_cnt + 1'b1);
                if (bit_cnt == 3'h7) begin
                    byte_stb <= 1'b1;
                    byte_val <= next_shift;
                end
            end
        end
    end

    // =========================================================
    // command decode
    // =========================================================
    drm_state_t state;
    drm_state_t next_state;
    logic       first_byte;
    logic [7:0] cmd;
    logic [2:0] arg_cnt;
    logic [7:0] part_first_row;
    logic [25:0] seq_cnt;

    wire is_cmd_byte = byte_stb && first_byte;
    wire sw_reset_trig = is_cmd_byte && (byte_val == CMD_SOFT_RESET);
    wire reset_trig    = hw_reset_trig || sw_reset_trig;
    wire seq_done      = (seq_cnt == 26'(RESET_SEQ_CYCLES - 1));
    wire is_upd_cmd    = (cmd == CMD_FULL_UPDATE) || (cmd == CMD_PART_UPDATE);
    // both update commands carry two argument bytes ahead of the image data
    wire arg_last      = byte_stb && !first_byte && (state == DRM_RECV) && (arg_cnt == 3'h1);
    wire fifo_wr_en    = byte_stb && !first_byte && (state == DRM_RECV)
                         && is_upd_cmd && (arg_cnt == 3'h2);

    // =========================================================
    // image byte buffer
    // =========================================================
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_rd;
    logic       fifo_wr_ready;

    drm_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .arst_n_in    (arst_n_in),
        .wr_data_in   (byte_val),
        .wr_valid_in  (fifo_wr_en),
        .wr_ready_out (fifo_wr_ready),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_rd),
        .flush_in     (reset_trig)
    );

    // =========================================================
    // pixel walker
    // =========================================================
    logic [7:0]  cur_col;
    logic [7:0]  cur_row;
    logic [12:0] bytes_left;
    logic [7:0]  pix_byte;
    logic [2:0]  pix_idx;
    logic        have_byte;
    logic        update_on;
    logic        overrun;

    // row count arrives in the last argument byte; nine bits so a large count cannot wrap
    wire [8:0] row_end      = 9'(part_first_row) + 9'(byte_val) - 9'h001;
    // the walker drains the buffer while bytes still arrive, since the host cannot be paused
    wire       walking      = (state == DRM_UPDATE) || ((state == DRM_RECV) && update_on);
    wire       need_byte    = walking && !have_byte && (bytes_left != 13'h0000);
    wire       cur_bit      = pix_byte[3'(PIX_PER_BYTE - 1) - pix_idx];
    wire       last_in_byte = (pix_idx == 3'(PIX_PER_BYTE - 1));
    wire       at_row_end   = (cur_col == LAST_COL);
    wire       edge_col     = (cur_col == 8'h00) || (cur_col == LAST_COL);
    wire       edge_row     = (cur_row == 8'h00) || (cur_row == LAST_ROW);

    assign fifo_rd = need_byte;

    function automatic logic [2:0] stretch(input logic on_edge);
        stretch = on_edge ? 3'(FRAME_STRETCH) : 3'h1;
    endfunction : stretch

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            have_byte <= 1'b0;
            pix_byte  <= 8'h00;
            pix_idx   <= 3'h0;
        end else if (need_byte && fifo_valid) begin
            have_byte <= 1'b1;
            pix_byte  <= fifo_data;
            pix_idx   <= 3'h0;
        end else if (have_byte) begin
            pix_idx <= 3'(pix_idx + 1'b1);
            if (last_in_byte)
                have_byte <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pix_col_out    <= 8'h00;
            pix_row_out    <= 8'h00;
            pix_bright_out <= 1'b0;
            pix_width_out  <= 3'h1;
            pix_height_out <= 3'h1;
            pix_valid_out  <= 1'b0;
        end else begin
            pix_valid_out <= have_byte && walking;
            if (have_byte && walking) begin
                pix_col_out    <= cur_col;
                pix_row_out    <= cur_row;
                pix_bright_out <= cur_bit;
                pix_width_out  <= stretch(edge_col);
                pix_height_out <= stretch(edge_row);
            end
        end
    end

    // raster order counters; rows restart at column zero
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur_col    <= 8'h00;
            cur_row    <= 8'h00;
            bytes_left <= 13'h0000;
            update_on  <= 1'b0;
        end else if (arg_last) begin
            cur_col <= 8'h00;
            if (cmd == CMD_FULL_UPDATE) begin
                cur_row    <= 8'h00;
                bytes_left <= LAST_FULL_BYTE + 13'h0001;
                update_on  <= 1'b1;
            end else if (cmd == CMD_PART_UPDATE) begin
                cur_row    <= part_first_row;
                bytes_left <= 13'(byte_val * BYTES_PER_ROW);
                update_on  <= (byte_val != 8'h00) && (row_end <= {1'b0, LAST_ROW});
            end
        end else if (is_cmd_byte) begin
            update_on <= 1'b0;
        end else if (need_byte && fifo_valid) begin
            bytes_left <= 13'(bytes_left - 1'b1);
        end else if (have_byte) begin
            if (at_row_end) begin
                cur_col <= 8'h00;
                cur_row <= 8'(cur_row + 1'b1);
            end else begin
                cur_col <= 8'(cur_col + 1'b1);
            end
            if (last_in_byte && bytes_left == 13'h0000)
                update_on <= 1'b0;
        end
    end

    // =========================================================
    // command argument capture
    // =========================================================
    // fifo refuses data while full; bytes then are dropped and the update
    // is abandoned, since the host gives no flow control during a packet
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            first_byte     <= 1'b1;
            cmd            <= 8'h00;
            arg_cnt        <= 3'h0;
            part_first_row <= 8'h00;
            overrun        <= 1'b0;
        end else begin
            if (cs_lvl) begin
                first_byte <= 1'b1;
                arg_cnt    <= 3'h0;
            end else if (byte_stb) begin
                first_byte <= 1'b0;
                if (first_byte) begin
                    cmd     <= byte_val;
                    overrun <= 1'b0;
                end else if (arg_cnt != 3'h2) begin
                    arg_cnt <= 3'(arg_cnt + 1'b1);
                    if (cmd == CMD_PART_UPDATE && arg_cnt == 3'h0)
                        part_first_row <= byte_val;
                end
                if (fifo_wr_en && !fifo_wr_ready)
                    overrun <= 1'b1;
            end
        end
    end

    // =========================================================
    // main sequencer
    // =========================================================
    always_comb begin
        next_state = state;
        case (state)
            DRM_RESETTING: if (seq_done) next_state = DRM_SLEEP;
            DRM_SLEEP:     if (is_cmd_byte) next_state = DRM_RECV;
            DRM_IDLE:      if (is_cmd_byte) next_state = DRM_RECV;
            DRM_RECV: begin
                if (cs_rise) begin
                    if (cmd == CMD_PP_CLEAR)
                        next_state = DRM_ERASE;
                    else if ((cmd == CMD_FULL_UPDATE || cmd == CMD_PART_UPDATE)
                             && !overrun)
                        next_state = DRM_UPDATE;
                    else if (cmd == CMD_SLEEP)
                        next_state = DRM_SLEEP;
                    else
                        next_state = DRM_IDLE;
                end
            end
            DRM_UPDATE: if (!update_on && state == DRM_UPDATE && !have_byte)
                            next_state = DRM_IDLE;
            DRM_ERASE:     next_state = DRM_IDLE;
            default:       next_state = DRM_RESETTING;
        endcase
        if (reset_trig)
            next_state = DRM_RESETTING;
    end

    // power-on: async reset lands in the resetting state
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state   <= DRM_RESETTING;
            seq_cnt <= 26'h0000000;
        end else begin
            state <= next_state;
            if (reset_trig || state != DRM_RESETTING)
                seq_cnt <= 26'h0000000;
            else if (!seq_done)
                seq_cnt <= 26'(seq_cnt + 1'b1);
        end
    end

    // =========================================================
    // status outputs
    // =========================================================
    wire next_busy = (next_state == DRM_RESETTING) || (next_state == DRM_UPDATE)
                     || (next_state == DRM_ERASE) || (next_state == DRM_RECV);

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_out            <= 1'b1;
            interpixel_dark_out <= 1'b0;
            sleeping_out        <= 1'b0;
        end else begin
            busy_out     <= next_busy && !(next_state == DRM_RECV);
            sleeping_out <= (next_state == DRM_SLEEP);
            // only erase darkens the gaps; updates leave them alone
            interpixel_dark_out <= (next_state == DRM_ERASE);
        end
    end
endmodule : drm_top

// ===== drm_top_properties.sv
`timescale 1ns/1ps
// ==========================================
// checker on the pins of the display block
module drm_top_properties
    import drm_pkg::*;
#(
    parameter int unsigned RESET_SEQ_CYCLES = RESET_SEQ_CYC
) (
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       arst_n_in,
    // host pins
    input wire logic       reset_pin_n_in,
    input wire logic       cs_n_in,
    input wire logic       sck_in,
    input wire logic       si_in,
    input wire logic       busy_out,
    // panel pixel stream
    input wire logic [7:0] pix_col_out,
    input wire logic [7:0] pix_row_out,
    input wire logic       pix_bright_out,
    input wire logic [2:0] pix_width_out,
    input wire logic [2:0] pix_height_out,
    input wire logic       pix_valid_out,
    input wire logic       interpixel_dark_out,
    input wire logic       sleeping_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    // ==========================================
    // helpers
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;
    logic [7:0] last_col;
    logic [7:0] last_row;
    logic       seen;
    // saturates so a long hold never wraps back under the pulse limit
    assign next_low_cnt = reset_pin_n_in ? 8'h00 :
                          (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            low_cnt  <= 8'h00;
            last_col <= 8'h00;
            last_row <= 8'h00;
            seen     <= 1'b0;
        end else begin
            low_cnt <= next_low_cnt;
            if (pix_valid_out) begin
                last_col <= pix_col_out;
                last_row <= pix_row_out;
                seen     <= 1'b1;
            end
        end
    end

    // ==========================================
    // assertions
    a_pin_reset_starts: assert property ($rose(reset_pin_n_in) && low_cnt >= 8'h68 |-> ##[1:6] busy_out)
        else $error("busy did not follow a long reset pulse");
    a_short_pulse_ignored: assert property ($rose(reset_pin_n_in) && low_cnt < 8'h50 && !busy_out
        |-> !busy_out [*6])
        else $error("short reset pulse started a sequence");
    a_pixel_in_range: assert property (pix_valid_out |-> pix_col_out <= LAST_COL && pix_row_out <= LAST_ROW)
        else $error("pixel outside the panel");
    a_frame_width: assert property (pix_valid_out |-> pix_width_out ==
        ((pix_col_out == 8'h00 || pix_col_out == LAST_COL) ? 3'h5 : 3'h1))
        else $error("wrong pixel width");
    a_frame_height: assert property (pix_valid_out |-> pix_height_out ==
        ((pix_row_out == 8'h00 || pix_row_out == LAST_ROW) ? 3'h5 : 3'h1))
        else $error("wrong pixel height");
    a_col_steps_right: assert property (pix_valid_out && seen && pix_row_out == last_row
        && last_col != LAST_COL |-> pix_col_out == last_col + 8'h01)
        else $error("column did not step right");
    a_dark_single_pulse: assert property (interpixel_dark_out |=> !interpixel_dark_out)
        else $error("interpixel dark longer than one cycle");
    a_dark_only_erase: assert property (interpixel_dark_out |-> busy_out && !pix_valid_out)
        else $error("interpixel dark outside erase");
    a_sleep_entry: assert property ($rose(sleeping_out) |-> !busy_out)
        else $error("asleep while busy");
    a_asleep_quiet: assert property (sleeping_out |-> !pix_valid_out && !interpixel_dark_out)
        else $error("activity while asleep");

    c_frame_pixel: cover property (pix_valid_out && pix_width_out == 3'h5);
    c_sleep: cover property ($rose(sleeping_out));
    c_erase: cover property (interpixel_dark_out);
    c_pin_reset: cover property ($rose(reset_pin_n_in) && low_cnt >= 8'h68);
endmodule : drm_top_properties

bind drm_top drm_top_properties #(.RESET_SEQ_CYCLES(RESET_SEQ_CYCLES)) i_drm_top_properties (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reset_pin_n_in(reset_pin_n_in),
    .cs_n_in(cs_n_in), .sck_in(sck_in), .si_in(si_in), .busy_out(busy_out),
    .pix_col_out(pix_col_out), .pix_row_out(pix_row_out), .pix_bright_out(pix_bright_out),
    .pix_width_out(pix_width_out), .pix_height_out(pix_height_out),
    .pix_valid_out(pix_valid_out), .interpixel_dark_out(interpixel_dark_out),
    .sleeping_out(sleeping_out));

// ===== drm_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host side: serial master and reset pin
module drm_host_model (
    // clock
    input  wire logic ref_clk_in,
    // host pins
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    output logic      reset_pin_n_out
);
    initial begin
        cs_n_out        = 1'b1;
        sck_out         = 1'b0;
        si_out          = 1'b0;
        // pin held low until the logic supply is taken as settled
        reset_pin_n_out = 1'b0;
        tick(2);
        reset_pin_n_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : tick
    // four cycles per half gives the 160 ns serial clock; it idles low between frames
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            si_out  = b[i];
            sck_out = 1'b1;
            tick(4);
            sck_out = 1'b0;
            tick(4);
        end
    endtask : send_byte
    task automatic start_pkt;
        cs_n_out = 1'b0;
        tick(8);
    endtask : start_pkt
    // data line is not held once deselected, so it flips to expose stale use
    task automatic end_pkt;
        tick(8);
        cs_n_out = 1'b1;
        si_out   = ~si_out;
        tick(8);
    endtask : end_pkt
    task automatic pulse_pin(input int n);
        reset_pin_n_out = 1'b0;
        tick(n);
        reset_pin_n_out = 1'b1;
        tick(1);
    endtask : pulse_pin
endmodule : drm_host_model

// ===== display_reset_image_mapping_bench.sv
`timescale 1ns/1ps
module display_reset_image_mapping_bench
    import drm_pkg::*;
;
    localparam int RSEQ = 200;
    logic ref_clk_in = 1'b0;
    logic arst_n_in  = 1'b0;
    logic cs_n, sck, si, rst_pin_n, busy_out, pix_bright_out, pix_valid_out;
    logic interpixel_dark_out, sleeping_out;
    logic [7:0] pix_col_out, pix_row_out;
    logic [2:0] pix_width_out, pix_height_out;
    int errors    = 0;
    int tests_run = 0;
    int dark_n    = 0;
    int seed      = 32'hcb383fdd;
    logic [22:0] exp_q[$];

    always #10 ref_clk_in = ~ref_clk_in;

    drm_top #(.RESET_SEQ_CYCLES(RSEQ)) i_drm_top (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reset_pin_n_in(rst_pin_n),
        .cs_n_in(cs_n), .sck_in(sck), .si_in(si), .busy_out(busy_out),
        .pix_col_out(pix_col_out), .pix_row_out(pix_row_out), .pix_bright_out(pix_bright_out),
        .pix_width_out(pix_width_out), .pix_height_out(pix_height_out),
        .pix_valid_out(pix_valid_out), .interpixel_dark_out(interpixel_dark_out),
        .sleeping_out(sleeping_out));
    drm_host_model i_drm_host_model (
        .ref_clk_in(ref_clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
        .reset_pin_n_out(rst_pin_n));

    // ==========================================
    // reporting and waits
    task automatic summarize;
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task automatic cyc;
        @(posedge ref_clk_in);
        #1;
    endtask : cyc
    task automatic wait_busy(input logic lvl, input int lim, output int n);
        n = 0;
        while (busy_out !== lvl) begin
            cyc();
            n++;
            if (n > lim) begin
                chk(1'b0, "wait on busy timed out");
                summarize();
            end
        end
    endtask : wait_busy
    task automatic reset_seq;
        int n;
        wait_busy(1'b1, 10, n);
        wait_busy(1'b0, RSEQ + 20, n);
        chk(n >= RSEQ - 6 && n <= RSEQ + 6, "reset sequence length");
        chk(sleeping_out === 1'b1, "not asleep after reset");
    endtask : reset_seq
    task automatic packet(input logic [7:0] cmd);
        int n;
        wait_busy(1'b0, 10, n);
        i_drm_host_model.start_pkt();
        i_drm_host_model.send_byte(cmd);
    endtask : packet

    // ==========================================
    // reference model of the pixel stream
    function automatic logic [22:0] pix(input int col, input int row, input logic b);
        int w, h;
        w = (col == 0 || col == NUM_COLS - 1) ? FRAME_STRETCH : 1;
        h = (row == 0 || row == NUM_ROWS - 1) ? FRAME_STRETCH : 1;
        return {8'(col), 8'(row), b, 3'(w), 3'(h)};
    endfunction : pix
    // image bytes stream while the packet is open; the walker keeps pace with them
    task automatic part_upd(input logic [7:0] cmd, input int row, input int nb);
        logic [7:0] b;
        int n;
        packet(cmd);
        i_drm_host_model.send_byte(8'(row));
        i_drm_host_model.send_byte(8'h01);
        for (int k = 0; k < nb; k++) begin
            b = 8'($random(seed));
            i_drm_host_model.send_byte(b);
            for (int j = 0; j < 8; j++) exp_q.push_back(pix(k * 8 + j, row, b[7-j]));
        end
        i_drm_host_model.end_pkt();
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            cyc();
            n++;
        end
        chk(exp_q.size() == 0, "pixels missing");
    endtask : part_upd

    always @(posedge ref_clk_in) begin : mon
        logic [22:0] e;
        if (pix_valid_out === 1'b1) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
            chk(e === {pix_col_out, pix_row_out, pix_bright_out, pix_width_out,
                       pix_height_out}, "pixel");
        end
        if (interpixel_dark_out === 1'b1) dark_n++;
    end

    // ==========================================
    // main sequence
    initial begin
        int hi;
        int rows[4];
        rows = '{0, 159, 1, 0};
        hi   = 0;
        repeat (3) @(posedge ref_clk_in);
        #1;
        arst_n_in = 1'b1;
        reset_seq();
        i_drm_host_model.pulse_pin(20);
        repeat (30) begin
            cyc();
            if (busy_out !== 1'b0) hi++;
        end
        chk(hi == 0, "short pulse started reset");
        foreach (rows[i]) begin
            if (i < 3) part_upd(CMD_PART_UPDATE, rows[i], BYTES_PER_ROW);
            else part_upd(CMD_FULL_UPDATE, rows[i], 8);
            i_drm_host_model.pulse_pin(110);
            reset_seq();
        end
        chk(dark_n == 0, "interpixel dark during updates");
        packet(CMD_SOFT_RESET);
        reset_seq();
        i_drm_host_model.end_pkt();
        packet(CMD_PP_CLEAR);
        i_drm_host_model.end_pkt();
        hi = 0;
        while (dark_n == 0 && hi < 20000) begin
            cyc();
            hi++;
        end
        wait_busy(1'b0, 20000, hi);
        chk(dark_n == 1, "erase pulse count");
        summarize();
    end
endmodule : display_reset_image_mapping_bench
